// File: design/dltc_pin_sync.sv
// Two-flop synchroniser with edge pulses for one pin
`timescale 1ns/100ps
module dltc_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level,
  output logic      fall,
  output logic      rise
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall  = prev_q & ~sync_q;
  assign rise  = ~prev_q & sync_q;
endmodule

// File: design/dltc_pkg.sv
// Constants for the dual timer/counter block
package dltc_pkg;
  localparam int          ADDR_W       = 10;
  localparam int          DIV_COUNT    = 12;
  localparam logic [3:0]  DIV_LAST     = 4'(DIV_COUNT - 1);
  localparam logic [3:0]  DIV_RST      = 4'h0;
  // Register indices; the byte address is four times the index
  localparam logic [7:0]  IDX_TCTRL    = 8'h88;
  localparam logic [7:0]  IDX_TMODE    = 8'h89;
  localparam logic [7:0]  IDX_T0_LOW   = 8'h8a;
  localparam logic [7:0]  IDX_T1_LOW   = 8'h8b;
  localparam logic [7:0]  IDX_T0_HIGH  = 8'h8c;
  localparam logic [7:0]  IDX_T1_HIGH  = 8'h8d;
  localparam logic [7:0]  IDX_CLKSEL   = 8'h8e;
  localparam logic [7:0]  IDX_AUX1     = 8'ha2;
  localparam logic [7:0]  IDX_P3MODE   = 8'hac;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'hf0;
  localparam logic [7:0]  IDX_IRQ_MASK = 8'hf1;
  localparam logic [7:0]  IDX_SVC_ACK  = 8'hf2;
  // Mode register fields
  localparam int          TM_GATE1     = 7;
  localparam int          TM_CT1       = 6;
  localparam int          TM_MODE1_LO  = 4;
  localparam int          TM_GATE0     = 3;
  localparam int          TM_CT0       = 2;
  localparam int          TM_MODE0_LO  = 0;
  // Control register fields
  localparam int          TC_TF1       = 7;
  localparam int          TC_TR1       = 6;
  localparam int          TC_TF0       = 5;
  localparam int          TC_TR0       = 4;
  // Clock select, auxiliary and port mode fields
  localparam int          CK_T1_FAST   = 4;
  localparam int          CK_T0_FAST   = 3;
  localparam int          AX_T1_XTAL   = 5;
  localparam int          AX_T0_XTAL   = 4;
  localparam int          PM_T1_OE     = 7;
  localparam int          PM_T0_OE     = 6;
  // Interrupt status, mask and service ack bits
  localparam int          IRQ_T0       = 0;
  localparam int          IRQ_T1       = 1;
  // Writable masks and reset values
  localparam logic [7:0]  CLKSEL_MASK  = 8'h18;
  localparam logic [7:0]  AUX1_MASK    = 8'hf9;
  localparam logic [7:0]  CLKSEL_RST   = 8'h00;
  localparam logic [7:0]  AUX1_RST     = 8'h00;
  localparam logic [7:0]  P3MODE_RST   = 8'h3f;
  localparam logic [7:0]  TMODE_RST    = 8'h00;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [1:0]  MODE_13BIT   = 2'h0;
  localparam logic [1:0]  MODE_16BIT   = 2'h1;
  localparam logic [1:0]  MODE_RELOAD  = 2'h2;
  localparam logic [1:0]  MODE_SPLIT   = 2'h3;
endpackage

// File: design/dltc_top.sv
// Dual timer/counter with Avalon-MM register access
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
module dltc_top
  import dltc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic              count_pin_zero_in,
  output logic                   count_pin_zero_out,
  output logic                   count_pin_zero_oe_n,
  input  wire logic              count_pin_one_in,
  output logic                   count_pin_one_out,
  output logic                   count_pin_one_oe_n,
  input  wire logic              gate_input_zero,
  input  wire logic              gate_input_one,
  input  wire logic              low_speed_crystal_clock,
  output logic                   baud_tick,
  output logic                   irq
);
  logic [7:0]  timer_mode_reg_q;
  logic [7:0]  timer_clock_select_q;
  logic [7:0]  auxiliary_control_one_q;
  logic [7:0]  port3_mode_select_one_q;
  logic        timer0_run_q;
  logic        timer1_run_q;
  logic        timer0_overflow_flag_q;
  logic        timer1_overflow_flag_q;
  logic [15:0] cnt0_q;
  logic [15:0] cnt1_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [3:0]  div_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        irq_q;
  logic        baud_q;
  logic        pin0_q;
  logic        pin1_q;
  logic        oe0_n_q;
  logic        oe1_n_q;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    return a[ADDR_W-1:2] == idx;
  endfunction

  // Returns {overflow, next count} for one increment in the given mode
  function automatic logic [16:0] step(input logic [1:0] m, input logic [15:0] v);
    logic [13:0] c13;
    logic [16:0] r;
    c13 = 14'({v[15:8], v[4:0]}) + 14'h0001;
    r   = {1'b0, v};
    case (m)
      MODE_13BIT: begin
        r = {c13[13], c13[12:5], v[7:5], c13[4:0]};
      end
      MODE_16BIT: begin
        r = 17'({1'b0, v}) + 17'h0_0001;
      end
      MODE_RELOAD: begin
        if (v[7:0] == 8'hff) begin
          r = {1'b1, v[15:8], v[15:8]};
        end else begin
          r = {1'b0, v[15:8], v[7:0] + 8'h01};
        end
      end
      default: begin
        r = {v[7:0] == 8'hff, v[15:8], v[7:0] + 8'h01};
      end
    endcase
    return r;
  endfunction

  // Pin synchronisers
  logic pin0_fall, pin1_fall;
  logic gate0_lvl, gate1_lvl, xtal_rise;

  dltc_pin_sync u_pin0 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (count_pin_zero_in),
    .level   (),
    .fall    (pin0_fall),
    .rise    ()
  );
  dltc_pin_sync u_pin1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (count_pin_one_in),
    .level   (),
    .fall    (pin1_fall),
    .rise    ()
  );
  dltc_pin_sync u_gate0 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (gate_input_zero),
    .level   (gate0_lvl),
    .fall    (),
    .rise    ()
  );
  dltc_pin_sync u_gate1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (gate_input_one),
    .level   (gate1_lvl),
    .fall    (),
    .rise    ()
  );
  dltc_pin_sync u_xtal (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .pin_in  (low_speed_crystal_clock),
    .level   (),
    .fall    (),
    .rise    (xtal_rise)
  );

  // Bus handshake: one wait state, then waitrequest low for one cycle
  logic wr_go, rd_go;
  assign wr_go = write & ~wait_q & byteenable[0];
  assign rd_go = read & ~wait_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((read | write) & wait_q);
    end
  end

  // Divide-by-twelve prescaler
  logic tick12;
  assign tick12 = (div_q == DIV_LAST);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= DIV_RST;
    end else begin
      div_q <= tick12 ? DIV_RST : div_q + 4'h1;
    end
  end

  // Tick selection and enables
  logic [1:0] mode0, mode1;
  logic       split0, itick0, itick1, tick0, tick1;
  logic       gok0, gok1, en0, en1, en0h;
  logic [16:0] nxt0, nxt1;
  logic       ovf0, ovf1, ovf0h, set_tf0, set_tf1;

  assign mode0  = timer_mode_reg_q[TM_MODE0_LO+:2];
  assign mode1  = timer_mode_reg_q[TM_MODE1_LO+:2];
  assign split0 = (mode0 == MODE_SPLIT);
  assign itick0 = timer_clock_select_q[CK_T0_FAST] | tick12;
  assign itick1 = timer_clock_select_q[CK_T1_FAST] | tick12;
  assign tick0  = auxiliary_control_one_q[AX_T0_XTAL] ? xtal_rise :
                  (timer_mode_reg_q[TM_CT0] ? pin0_fall : itick0);
  assign tick1  = auxiliary_control_one_q[AX_T1_XTAL] ? xtal_rise :
                  (timer_mode_reg_q[TM_CT1] ? pin1_fall : itick1);
  assign gok0   = ~timer_mode_reg_q[TM_GATE0] | gate0_lvl;
  assign gok1   = ~timer_mode_reg_q[TM_GATE1] | gate1_lvl;
  assign en0    = tick0 & timer0_run_q & gok0;
  // Timer 1 loses its run bit to the split high byte
  assign en1    = tick1 & gok1 & (split0 | timer1_run_q) & (mode1 != MODE_SPLIT);
  assign en0h   = split0 & itick0 & timer1_run_q;
  assign nxt0   = step(mode0, cnt0_q);
  assign nxt1   = step(mode1, cnt1_q);
  assign ovf0   = en0 & nxt0[16];
  assign ovf1   = en1 & nxt1[16];
  assign ovf0h  = en0h & (cnt0_q[15:8] == 8'hff);
  assign set_tf0 = ovf0;
  assign set_tf1 = split0 ? ovf0h : ovf1;

  // Count registers; a software byte write wins over counting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt0_q <= COUNT_RST;
    end else begin
      if (en0) begin
        cnt0_q[7:0] <= nxt0[7:0];
        if (!split0) begin
          cnt0_q[15:8] <= nxt0[15:8];
        end
      end
      if (en0h) begin
        cnt0_q[15:8] <= cnt0_q[15:8] + 8'h01;
      end
      if (wr_go && hit(address, IDX_T0_LOW)) begin
        cnt0_q[7:0] <= writedata[7:0];
      end
      if (wr_go && hit(address, IDX_T0_HIGH)) begin
        cnt0_q[15:8] <= writedata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt1_q <= COUNT_RST;
    end else begin
      if (en1) begin
        cnt1_q <= nxt1[15:0];
      end
      if (wr_go && hit(address, IDX_T1_LOW)) begin
        cnt1_q[7:0] <= writedata[7:0];
      end
      if (wr_go && hit(address, IDX_T1_HIGH)) begin
        cnt1_q[15:8] <= writedata[7:0];
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_mode_reg_q        <= TMODE_RST;
      timer_clock_select_q    <= CLKSEL_RST;
      auxiliary_control_one_q <= AUX1_RST;
      port3_mode_select_one_q <= P3MODE_RST;
      irq_mask_q              <= 2'h0;
      timer0_run_q            <= 1'b0;
      timer1_run_q            <= 1'b0;
    end else if (wr_go) begin
      if (hit(address, IDX_TMODE)) begin
        timer_mode_reg_q <= writedata[7:0];
      end
      if (hit(address, IDX_CLKSEL)) begin
        timer_clock_select_q <= writedata[7:0] & CLKSEL_MASK;
      end
      if (hit(address, IDX_AUX1)) begin
        auxiliary_control_one_q <= writedata[7:0] & AUX1_MASK;
      end
      if (hit(address, IDX_P3MODE)) begin
        port3_mode_select_one_q <= writedata[7:0];
      end
      if (hit(address, IDX_IRQ_MASK)) begin
        irq_mask_q <= writedata[1:0];
      end
      if (hit(address, IDX_TCTRL)) begin
        timer0_run_q <= writedata[TC_TR0];
        timer1_run_q <= writedata[TC_TR1];
      end
    end
  end

  // Overflow flags: hardware set wins over any clear
  logic wr_tc, wr_ack;
  assign wr_tc  = wr_go & hit(address, IDX_TCTRL);
  assign wr_ack = wr_go & hit(address, IDX_SVC_ACK);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer0_overflow_flag_q <= 1'b0;
      timer1_overflow_flag_q <= 1'b0;
    end else begin
      if (set_tf0) begin
        timer0_overflow_flag_q <= 1'b1;
      end else if (wr_tc) begin
        timer0_overflow_flag_q <= writedata[TC_TF0];
      end else if (wr_ack && writedata[IRQ_T0]) begin
        timer0_overflow_flag_q <= 1'b0;
      end
      if (set_tf1) begin
        timer1_overflow_flag_q <= 1'b1;
      end else if (wr_tc) begin
        timer1_overflow_flag_q <= writedata[TC_TF1];
      end else if (wr_ack && writedata[IRQ_T1]) begin
        timer1_overflow_flag_q <= 1'b0;
      end
    end
  end

  // Sticky interrupt status, cleared by reading it; set wins
  logic rd_stat;
  assign rd_stat = rd_go & hit(address, IDX_IRQ_STAT);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= 2'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= (rd_stat ? 2'h0 : irq_stat_q) | {set_tf1, set_tf0};
      irq_q      <= |(((rd_stat ? 2'h0 : irq_stat_q) | {set_tf1, set_tf0}) & irq_mask_q);
    end
  end

  // Baud tick from timer 1 only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      baud_q <= 1'b0;
    end else begin
      baud_q <= ovf1;
    end
  end

  // Pin outputs toggle on overflow
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin0_q  <= 1'b0;
      pin1_q  <= 1'b0;
      oe0_n_q <= 1'b1;
      oe1_n_q <= 1'b1;
    end else begin
      pin0_q  <= pin0_q ^ ovf0;
      pin1_q  <= pin1_q ^ ovf1;
      oe0_n_q <= ~port3_mode_select_one_q[PM_T0_OE];
      oe1_n_q <= ~port3_mode_select_one_q[PM_T1_OE];
    end
  end

  // Read data, loaded while waitrequest is still high
  function automatic logic [7:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (hit(a, IDX_TCTRL)) begin
      r = {timer1_overflow_flag_q, timer1_run_q, timer0_overflow_flag_q, timer0_run_q, 4'h0};
    end
    if (hit(a, IDX_TMODE))    r = timer_mode_reg_q;
    if (hit(a, IDX_T0_LOW))   r = cnt0_q[7:0];
    if (hit(a, IDX_T1_LOW))   r = cnt1_q[7:0];
    if (hit(a, IDX_T0_HIGH))  r = cnt0_q[15:8];
    if (hit(a, IDX_T1_HIGH))  r = cnt1_q[15:8];
    if (hit(a, IDX_CLKSEL))   r = timer_clock_select_q;
    if (hit(a, IDX_AUX1))     r = auxiliary_control_one_q;
    if (hit(a, IDX_P3MODE))   r = port3_mode_select_one_q;
    if (hit(a, IDX_IRQ_STAT)) r = {6'h00, irq_stat_q};
    if (hit(a, IDX_IRQ_MASK)) r = {6'h00, irq_mask_q};
    return r;
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && wait_q) begin
      rdata_q <= {24'h00_0000, rd_mux(address)};
    end
  end

  assign readdata            = rdata_q;
  assign waitrequest         = wait_q;
  assign irq                 = irq_q;
  assign baud_tick           = baud_q;
  assign count_pin_zero_out  = pin0_q;
  assign count_pin_one_out   = pin1_q;
  assign count_pin_zero_oe_n = oe0_n_q;
  assign count_pin_one_oe_n  = oe1_n_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  div_tick_spacing_a: assert property (tick12 |-> ##12 tick12)
    else $error("Prescaler tick not every twelve cycles");
  mode0_rollover_a: assert property (en0 && mode0 == MODE_13BIT && cnt0_q[15:8] == 8'hff
    && cnt0_q[4:0] == 5'h1f && !wr_go |=> timer0_overflow_flag_q && cnt0_q[15:8] == 8'h00 && cnt0_q[4:0] == 5'h00)
    else $error("Mode 0 rollover wrong");
  mode1_rollover_a: assert property (en0 && mode0 == MODE_16BIT && cnt0_q == 16'hffff && !wr_go
    |=> timer0_overflow_flag_q && cnt0_q == 16'h0000)
    else $error("Mode 1 rollover wrong");
  mode2_reload_a: assert property (en1 && !split0 && mode1 == MODE_RELOAD && cnt1_q[7:0] == 8'hff
    && !wr_go |=> cnt1_q[7:0] == $past(cnt1_q[15:8]) && $stable(cnt1_q[15:8]) && timer1_overflow_flag_q)
    else $error("Mode 2 reload wrong");
  run_halt_hold_a: assert property (!timer0_run_q && !timer1_run_q && !wr_go |=> $stable(cnt0_q))
    else $error("Halted timer 0 changed");
  t1_split_freeze_a: assert property (mode1 == MODE_SPLIT && !wr_go |=> $stable(cnt1_q))
    else $error("Timer 1 in mode 3 changed");
  baud_source_a: assert property (baud_tick |-> $past(en1) && $past(nxt1[16]))
    else $error("Baud tick without timer 1 overflow");
  split_high_flag_a: assert property (split0 && en0h && cnt0_q[15:8] == 8'hff
    |=> timer1_overflow_flag_q && cnt0_q[15:8] == 8'h00 || $past(wr_go))
    else $error("Split high byte overflow missed");
  pin_toggle_a: assert property ($changed(count_pin_zero_out) |-> $past(ovf0))
    else $error("Pin 0 toggled without overflow");
  gate_block_a: assert property (timer_mode_reg_q[TM_GATE0] && !gate0_lvl && !split0 && !wr_go
    |=> $stable(cnt0_q))
    else $error("Gated timer 0 counted");
endmodule

// File: testbench/dltc_far_model.sv
// Far-side model: count pins, gate inputs, slow crystal clock, baud tick counter
`timescale 1ns/100ps
module dltc_far_model (
  input  wire logic clk_sys,
  input  wire logic count_pin_zero_out,
  input  wire logic count_pin_zero_oe_n,
  input  wire logic count_pin_one_out,
  input  wire logic count_pin_one_oe_n,
  input  wire logic baud_tick,
  output logic      count_pin_zero_in,
  output logic      count_pin_one_in,
  output logic      gate_input_zero,
  output logic      gate_input_one,
  output logic      low_speed_crystal_clock,
  output int        baud_count
);
  logic [1:0] ext_q;
  initial begin
    ext_q <= 2'h3;
    gate_input_zero <= 1'b0;
    gate_input_one <= 1'b0;
    low_speed_crystal_clock <= 1'b0;
    baud_count <= 0;
  end
  // Pin level: device drives while enable is low, else external drive with pull-up
  assign count_pin_zero_in = count_pin_zero_oe_n ? ext_q[0] : count_pin_zero_out;
  assign count_pin_one_in  = count_pin_one_oe_n ? ext_q[1] : count_pin_one_out;
  always @(posedge clk_sys) begin
    if (baud_tick === 1'b1) begin
      baud_count <= baud_count + 1;
    end
  end
  // Falling edges spaced well beyond the synchroniser delay
  task automatic pulses(input int which, input int n);
    repeat (n) begin
      ext_q[which] <= 1'b0;
      repeat (3) @(posedge clk_sys);
      ext_q[which] <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic xtal_edges(input int n);
    repeat (n) begin
      low_speed_crystal_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      low_speed_crystal_clock <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic gates(input logic [1:0] g);
    {gate_input_one, gate_input_zero} <= g;
    @(posedge clk_sys);
  endtask
endmodule

// File: testbench/dltc_top_tb.sv
// Testbench for the dual timer/counter
`timescale 1ns/100ps
module dltc_top_tb
  import dltc_pkg::*;
;
  logic              clk_sys, rst_n, read, write;
  logic [ADDR_W-1:0] address;
  logic [31:0]       writedata, readdata;
  logic [3:0]        byteenable;
  logic              waitrequest, baud_tick, irq, xtal, g0, g1;
  logic              p0_in, p0_out, p0_oe_n, p1_in, p1_out, p1_oe_n;
  int                mismatches, samples_checked, bauds;
  logic [7:0]        v;

  dltc_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .count_pin_zero_in(p0_in), .count_pin_zero_out(p0_out), .count_pin_zero_oe_n(p0_oe_n),
    .count_pin_one_in(p1_in), .count_pin_one_out(p1_out), .count_pin_one_oe_n(p1_oe_n),
    .gate_input_zero(g0), .gate_input_one(g1), .low_speed_crystal_clock(xtal),
    .baud_tick(baud_tick), .irq(irq));
  dltc_far_model far (.clk_sys(clk_sys), .count_pin_zero_out(p0_out), .count_pin_zero_oe_n(p0_oe_n),
    .count_pin_one_out(p1_out), .count_pin_one_oe_n(p1_oe_n), .baud_tick(baud_tick),
    .count_pin_zero_in(p0_in), .count_pin_one_in(p1_in), .gate_input_zero(g0),
    .gate_input_one(g1), .low_speed_crystal_clock(xtal), .baud_count(bauds));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    address   <= {idx, 2'b00};
    writedata <= {24'h00_0000, d};
    write     <= w;
    read      <= !w;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata[7:0];
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, idx, d, q);
  endtask
  task automatic rc(input string what, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, idx, 8'h00, q);
    chk(what, q, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst_n <= 1'b0;
    read <= 1'b0;
    write <= 1'b0;
    address <= '0;
    writedata <= '0;
    byteenable <= 4'hf;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    // Reset values, writable masks, unmapped place
    rc("clksel", IDX_CLKSEL, CLKSEL_RST);
    rc("aux1", IDX_AUX1, AUX1_RST);
    rc("p3mode", IDX_P3MODE, P3MODE_RST);
    rc("tmode", IDX_TMODE, TMODE_RST);
    rc("unmapped", 8'h10, 8'h00);
    wr(IDX_CLKSEL, 8'hff);
    rc("clksel mask", IDX_CLKSEL, CLKSEL_MASK);
    wr(IDX_AUX1, 8'hff);
    rc("aux1 mask", IDX_AUX1, AUX1_MASK);
    wr(IDX_AUX1, 8'h00);
    // Full clock against divided clock
    wr(IDX_TMODE, 8'h11);
    wr(IDX_TCTRL, 8'h10);
    repeat (120) @(posedge clk_sys);
    wr(IDX_TCTRL, 8'h00);
    acc(1'b0, IDX_T0_LOW, 8'h00, v);
    chk("fast count", v >= 8'd120 && v <= 8'd127, 8'h01);
    wr(IDX_T0_LOW, 8'h00);
    wr(IDX_CLKSEL, 8'h00);
    wr(IDX_TCTRL, 8'h10);
    repeat (120) @(posedge clk_sys);
    wr(IDX_TCTRL, 8'h00);
    acc(1'b0, IDX_T0_LOW, 8'h00, v);
    chk("div count", v >= 8'd9 && v <= 8'd11, 8'h01);
    // Crystal clock input
    wr(IDX_T0_LOW, 8'h00);
    wr(IDX_AUX1, 8'h10);
    wr(IDX_TCTRL, 8'h10);
    far.xtal_edges(5);
    wr(IDX_TCTRL, 8'h00);
    rc("xtal count", IDX_T0_LOW, 8'h05);
    // Mode 0 counter rollover from 1FFF
    wr(IDX_AUX1, 8'h00);
    wr(IDX_TMODE, 8'h04);
    wr(IDX_T0_HIGH, 8'hff);
    wr(IDX_T0_LOW, 8'hfe);
    wr(IDX_TCTRL, 8'h10);
    far.pulses(0, 1);
    acc(1'b0, IDX_T0_LOW, 8'h00, v);
    chk("m0 low", v & 8'h1f, 8'h1f);
    rc("m0 no flag", IDX_TCTRL, 8'h10);
    far.pulses(0, 1);
    acc(1'b0, IDX_T0_LOW, 8'h00, v);
    chk("m0 wrap low", v & 8'h1f, 8'h00);
    rc("m0 wrap high", IDX_T0_HIGH, 8'h00);
    rc("m0 flag", IDX_TCTRL, 8'h30);
    chk("pin0 toggle", p0_out, 8'h01);
    rc("status", IDX_IRQ_STAT, 8'h01);
    rc("status clear", IDX_IRQ_STAT, 8'h00);
    chk("irq masked", irq, 8'h00);
    wr(IDX_SVC_ACK, 8'h01);
    rc("ack clears", IDX_TCTRL, 8'h10);
    wr(IDX_TCTRL, 8'h30);
    rc("sw set", IDX_TCTRL, 8'h30);
    // Mode 1 rollover with interrupt enabled
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_TCTRL, 8'h10);
    wr(IDX_TMODE, 8'h05);
    wr(IDX_T0_HIGH, 8'hff);
    wr(IDX_T0_LOW, 8'hff);
    far.pulses(0, 1);
    rc("m1 low", IDX_T0_LOW, 8'h00);
    rc("m1 high", IDX_T0_HIGH, 8'h00);
    chk("irq on", irq, 8'h01);
    chk("pin0 back", p0_out, 8'h00);
    rc("m1 status", IDX_IRQ_STAT, 8'h01);
    rc("m1 flag", IDX_TCTRL, 8'h30);
    chk("irq off", irq, 8'h00);
    // Gate level and run bit
    wr(IDX_TMODE, 8'h0d);
    wr(IDX_T0_LOW, 8'h00);
    far.pulses(0, 2);
    rc("gated", IDX_T0_LOW, 8'h00);
    far.gates(2'b01);
    far.pulses(0, 2);
    rc("gate open", IDX_T0_LOW, 8'h02);
    wr(IDX_TCTRL, 8'h00);
    far.pulses(0, 2);
    rc("halted", IDX_T0_LOW, 8'h02);
    // Write without the low byte lane is ignored
    byteenable <= 4'he;
    wr(IDX_T0_LOW, 8'h55);
    byteenable <= 4'hf;
    rc("be ignored", IDX_T0_LOW, 8'h02);
    // Timer 1 auto-reload and baud source
    wr(IDX_TMODE, 8'h60);
    wr(IDX_T1_HIGH, 8'h80);
    wr(IDX_T1_LOW, 8'hff);
    wr(IDX_TCTRL, 8'h40);
    far.pulses(1, 2);
    rc("reload low", IDX_T1_LOW, 8'h81);
    rc("reload high", IDX_T1_HIGH, 8'h80);
    rc("t1 flag", IDX_TCTRL, 8'hc0);
    chk("baud", 8'(bauds), 8'h01);
    chk("pin1 toggle", p1_out, 8'h01);
    wr(IDX_TMODE, 8'h70);
    far.pulses(1, 2);
    rc("t1 frozen", IDX_T1_LOW, 8'h81);
    // Split mode
    wr(IDX_TCTRL, 8'h00);
    wr(IDX_TMODE, 8'h67);
    wr(IDX_T0_LOW, 8'hff);
    wr(IDX_T0_HIGH, 8'h00);
    wr(IDX_T1_LOW, 8'hff);
    wr(IDX_TCTRL, 8'h10);
    far.pulses(0, 1);
    far.pulses(1, 1);
    rc("split low", IDX_T0_LOW, 8'h00);
    rc("t1 no run", IDX_T1_LOW, 8'h80);
    rc("split flags", IDX_TCTRL, 8'h30);
    rc("high idle", IDX_T0_HIGH, 8'h00);
    chk("baud split", 8'(bauds), 8'h02);
    wr(IDX_CLKSEL, 8'h08);
    wr(IDX_TCTRL, 8'h50);
    repeat (300) @(posedge clk_sys);
    rc("high flag", IDX_TCTRL, 8'hd0);
    wr(IDX_TCTRL, 8'h00);
    // Pin output enable
    wr(IDX_P3MODE, 8'h7f);
    rc("p3mode", IDX_P3MODE, 8'h7f);
    chk("oe0", p0_oe_n, 8'h00);
    chk("oe1", p1_oe_n, 8'h01);
    // Reset in mid-run returns pin enables and counts to their reset values
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("oe0 reset", p0_oe_n, 8'h01);
    rc("p3mode reset", IDX_P3MODE, P3MODE_RST);
    rc("t0 low reset", IDX_T0_LOW, 8'h00);
    report_and_stop();
  end
endmodule
